// [src/sag_regs.vh]
`ifndef SAG_REGS_VH
`define SAG_REGS_VH

// ***************************************************
// nonvolatile code memory map (word addresses)
// ***************************************************
`define SAG_FUSE_ADDR      16'hFF80
`define SAG_DBG_PWD_ADDR   16'hFF82
`define SAG_ZLO_ADDR       16'hFF84
`define SAG_ZHI_ADDR       16'hFF86
`define SAG_ZCTL_ADDR      16'hFF88
`define SAG_VEC_BASE       16'hFFE0
`define SAG_VEC_WORDS      16'h0010
`define SAG_CODE_BASE      16'h4000
`define SAG_CODE_WORDS     16'hC000

// ***************************************************
// stored signatures and fixed values
// ***************************************************
`define SAG_FUSE_PWD       16'hA5A5
`define SAG_FUSE_OFF       16'h5A5A
`define SAG_ZCTL_ARM       16'h00A1
`define SAG_ZCTL_MAPPED    16'h00C3
`define SAG_BLOCK_VAL      16'h3FFF
`define SAG_ERASE_VAL      16'hFFFF

// ***************************************************
// request sources and kinds
// ***************************************************
`define SAG_SRC_CPU        2'h0
`define SAG_SRC_DMA        2'h1
`define SAG_SRC_DBG        2'h2
`define SAG_SRC_BL         2'h3
`define SAG_KIND_READ      2'h0
`define SAG_KIND_WRITE     2'h1
`define SAG_KIND_FETCH     2'h2
`define SAG_KIND_PWD       2'h3

// ***************************************************
// debug port modes
// ***************************************************
`define SAG_DBG_OPEN       2'h0
`define SAG_DBG_PWD        2'h1
`define SAG_DBG_OFF        2'h2

`endif

// [src/sag_zone_check.v]
// ***************************************************
// secure zone range compare
// ***************************************************
module sag_zone_check #(
   parameter AW = 16
) (
   input  wire [AW-1:0] addr,
   input  wire [AW-1:0] zoneLo,
   input  wire [AW-1:0] zoneHi,
   input  wire          zoneOn,
   output wire          hit
);
   // inclusive bounds; an unmapped zone never hits
   assign hit = zoneOn && (addr >= zoneLo) && (addr <= zoneHi);
endmodule // sag_zone_check

// [src/sag_pwd_check.v]
`include "sag_regs.vh"

// ***************************************************
// boot loader password word sequencer
// ***************************************************
module sag_pwd_check #(
   parameter AW = 16
) (
   input  wire          clk_sys,
   input  wire          rstn,
   input  wire          step,
   input  wire          match,
   output wire [AW-1:0] idx,
   output wire          last,
   output wire          allOk
);
   reg [AW-1:0] idx_ff;
   reg          bad_ff;

   assign idx   = idx_ff;
   assign last  = (idx_ff == `SAG_VEC_WORDS - 16'h0001);
   // whole table must match; one bad word spoils the set
   assign allOk = !bad_ff && match;

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         idx_ff <= {AW{1'b0}};
         bad_ff <= 1'b0;
      end else if (step) begin
         if (last) begin
            idx_ff <= {AW{1'b0}};
            bad_ff <= 1'b0;
         end else begin
            idx_ff <= idx_ff + {{(AW-1){1'b0}}, 1'b1};
            bad_ff <= bad_ff | !match;
         end
      end
   end
endmodule // sag_pwd_check

// [src/sag_guard.v]
`include "sag_regs.vh"

// How it works
// - debug port opens freely, needs a password, or is off by fuse signature.
// - with debug off, debug requests are refused; CPU, DMA and boot loader paths still reach memory.
// - boot loader transfers refused until a full password is accepted.
// - boot loader password compared with current interrupt vector table words.
// - wrong boot loader password mass erases the whole code area.
// - stored zone range is mapped at the power cycle after it was armed.
// - once mapped, requested writes to the zone range words are refused; only the mass erase overwrites them.
// - debug, boot loader, DMA and CPU data reads from code outside the zone into the zone are blocked.
// - a call instruction from outside may fetch into the secure zone.
// - zone data reads allowed only while executing code inside the zone.
module sag_guard #(
   parameter AW         = 16,
   parameter DW         = 16,
   parameter [AW-1:0] CODE_WORDS = `SAG_CODE_WORDS
) (
   input  wire          clk_sys,
   input  wire          rstn,
   input  wire          reqValid,
   input  wire [1:0]    reqSrc,
   input  wire [1:0]    reqKind,
   input  wire [AW-1:0] reqAddr,
   input  wire [DW-1:0] reqWdata,
   input  wire [AW-1:0] cpuPc,
   input  wire          cpuCall,
   output reg           busy_ff,
   output reg           rspValid_ff,
   output reg  [DW-1:0] rspData_ff,
   output reg           rspDenied_ff,
   output reg           memReq_ff,
   output reg           memWe_ff,
   output reg  [AW-1:0] memAddr_ff,
   output reg  [DW-1:0] memWdata_ff,
   input  wire [DW-1:0] memRdata,
   output reg  [1:0]    dbgMode_ff,
   output reg           dbgOpen_ff,
   output reg           blOpen_ff,
   output reg           zoneMapped_ff,
   output reg           eraseActive_ff
);

   // ***************************************************
   // states
   // ***************************************************
   localparam [3:0] S_BRD   = 4'h0;
   localparam [3:0] S_BWT   = 4'h1;
   localparam [3:0] S_BCAP  = 4'h2;
   localparam [3:0] S_BMAP  = 4'h3;
   localparam [3:0] S_IDLE  = 4'h4;
   localparam [3:0] S_RWT   = 4'h5;
   localparam [3:0] S_RCAP  = 4'h6;
   localparam [3:0] S_PWT   = 4'h7;
   localparam [3:0] S_PCAP  = 4'h8;
   localparam [3:0] S_ERASE = 4'h9;

   reg [3:0]    state_ff;
   reg [1:0]    bootIdx_ff;
   reg [1:0]    src_ff;
   reg [DW-1:0] wdata_ff;
   reg [AW-1:0] zoneLo_ff;
   reg [AW-1:0] zoneHi_ff;
   reg [DW-1:0] zctl_ff;
   reg [AW-1:0] eraseCnt_ff;

   reg [3:0]    nxt_state;
   reg [1:0]    nxt_bootIdx;
   reg [1:0]    nxt_src;
   reg [DW-1:0] nxt_wdata;
   reg [AW-1:0] nxt_zoneLo;
   reg [AW-1:0] nxt_zoneHi;
   reg [DW-1:0] nxt_zctl;
   reg [AW-1:0] nxt_eraseCnt;
   reg          nxt_rspValid;
   reg [DW-1:0] nxt_rspData;
   reg          nxt_rspDenied;
   reg          nxt_memReq;
   reg          nxt_memWe;
   reg [AW-1:0] nxt_memAddr;
   reg [DW-1:0] nxt_memWdata;
   reg [1:0]    nxt_dbgMode;
   reg          nxt_dbgOpen;
   reg          nxt_blOpen;
   reg          nxt_zoneMapped;

   reg          allow;
   reg [AW-1:0] bootAddr;

   wire          addrInZone;
   wire          pcInZone;
   wire          cfgHit;
   wire          pwStep;
   wire          pwMatch;
   wire [AW-1:0] pwIdx;
   wire          pwLast;
   wire          pwOk;

   // ***************************************************
   // zone and password helpers
   // ***************************************************
   sag_zone_check #(.AW(AW)) u_addr_zone (
      .addr   (reqAddr),
      .zoneLo (zoneLo_ff),
      .zoneHi (zoneHi_ff),
      .zoneOn (zoneMapped_ff),
      .hit    (addrInZone)
   );

   sag_zone_check #(.AW(AW)) u_pc_zone (
      .addr   (cpuPc),
      .zoneLo (zoneLo_ff),
      .zoneHi (zoneHi_ff),
      .zoneOn (zoneMapped_ff),
      .hit    (pcInZone)
   );

   // table words are read from memory each time, so the password tracks
   // whatever vector table is stored right now
   assign pwMatch = (memRdata == wdata_ff);
   assign pwStep  = (state_ff == S_PCAP) && (src_ff == `SAG_SRC_BL);

   sag_pwd_check #(.AW(AW)) u_pwd (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .step    (pwStep),
      .match   (pwMatch),
      .idx     (pwIdx),
      .last    (pwLast),
      .allOk   (pwOk)
   );

   // range words are frozen once the zone is mapped
   assign cfgHit = zoneMapped_ff &&
                   ((reqAddr == `SAG_ZLO_ADDR) || (reqAddr == `SAG_ZHI_ADDR) ||
                    (reqAddr == `SAG_ZCTL_ADDR));

   // ***************************************************
   // access decision
   // ***************************************************
   always @* begin
      allow = 1'b0;
      case (reqSrc)
         `SAG_SRC_CPU: begin
            // data access only from code running inside the zone
            allow = !addrInZone || pcInZone;
            if (reqKind == `SAG_KIND_FETCH && cpuCall) begin
               allow = 1'b1;
            end
         end
         `SAG_SRC_DMA: begin
            allow = !addrInZone;
         end
         `SAG_SRC_DBG: begin
            allow = (dbgMode_ff == `SAG_DBG_OPEN ||
                     (dbgMode_ff == `SAG_DBG_PWD && dbgOpen_ff)) &&
                    !addrInZone;
         end
         default: begin
            allow = blOpen_ff && !addrInZone;
         end
      endcase
      if (reqKind == `SAG_KIND_WRITE && cfgHit) begin
         allow = 1'b0;
      end
   end

   always @* begin
      case (bootIdx_ff)
         2'h0:    bootAddr = `SAG_FUSE_ADDR;
         2'h1:    bootAddr = `SAG_ZLO_ADDR;
         2'h2:    bootAddr = `SAG_ZHI_ADDR;
         default: bootAddr = `SAG_ZCTL_ADDR;
      endcase
   end

   // ***************************************************
   // sequencer
   // ***************************************************
   always @* begin
      nxt_state      = state_ff;
      nxt_bootIdx    = bootIdx_ff;
      nxt_src        = src_ff;
      nxt_wdata      = wdata_ff;
      nxt_zoneLo     = zoneLo_ff;
      nxt_zoneHi     = zoneHi_ff;
      nxt_zctl       = zctl_ff;
      nxt_eraseCnt   = eraseCnt_ff;
      nxt_rspValid   = 1'b0;
      nxt_rspData    = rspData_ff;
      nxt_rspDenied  = rspDenied_ff;
      nxt_memReq     = 1'b0;
      nxt_memWe      = 1'b0;
      nxt_memAddr    = memAddr_ff;
      nxt_memWdata   = memWdata_ff;
      nxt_dbgMode    = dbgMode_ff;
      nxt_dbgOpen    = dbgOpen_ff;
      nxt_blOpen     = blOpen_ff;
      nxt_zoneMapped = zoneMapped_ff;
      case (state_ff)
         S_BRD: begin
            nxt_memReq  = 1'b1;
            nxt_memAddr = bootAddr;
            nxt_state   = S_BWT;
         end
         S_BWT: begin
            nxt_state = S_BCAP;
         end
         S_BCAP: begin
            case (bootIdx_ff)
               2'h0: begin
                  if (memRdata == `SAG_FUSE_OFF) begin
                     nxt_dbgMode = `SAG_DBG_OFF;
                  end else if (memRdata == `SAG_FUSE_PWD) begin
                     nxt_dbgMode = `SAG_DBG_PWD;
                  end else begin
                     nxt_dbgMode = `SAG_DBG_OPEN;
                  end
               end
               2'h1:    nxt_zoneLo = memRdata[AW-1:0];
               2'h2:    nxt_zoneHi = memRdata[AW-1:0];
               default: nxt_zctl   = memRdata;
            endcase
            nxt_bootIdx = bootIdx_ff + 2'h1;
            nxt_state   = (bootIdx_ff == 2'h3) ? S_BMAP : S_BRD;
         end
         S_BMAP: begin
            // an armed range only takes effect at the next power cycle;
            // the mapped mark is persisted so it cannot be re-armed until a mass erase wipes it
            if (zctl_ff == `SAG_ZCTL_ARM) begin
               nxt_memReq     = 1'b1;
               nxt_memWe      = 1'b1;
               nxt_memAddr    = `SAG_ZCTL_ADDR;
               nxt_memWdata   = `SAG_ZCTL_MAPPED;
               nxt_zoneMapped = 1'b1;
            end else if (zctl_ff == `SAG_ZCTL_MAPPED) begin
               nxt_zoneMapped = 1'b1;
            end
            nxt_state = S_IDLE;
         end
         S_IDLE: begin
            if (reqValid) begin
               nxt_src   = reqSrc;
               nxt_wdata = reqWdata;
               if (reqKind == `SAG_KIND_PWD) begin
                  if (reqSrc == `SAG_SRC_BL) begin
                     nxt_memReq  = 1'b1;
                     nxt_memAddr = `SAG_VEC_BASE + pwIdx;
                     nxt_state   = S_PWT;
                  end else if (reqSrc == `SAG_SRC_DBG &&
                               dbgMode_ff == `SAG_DBG_PWD) begin
                     nxt_memReq  = 1'b1;
                     nxt_memAddr = `SAG_DBG_PWD_ADDR;
                     nxt_state   = S_PWT;
                  end else begin
                     nxt_rspValid  = 1'b1;
                     nxt_rspData   = `SAG_BLOCK_VAL;
                     nxt_rspDenied = 1'b1;
                  end
               end else if (allow) begin
                  nxt_memReq   = 1'b1;
                  nxt_memWe    = (reqKind == `SAG_KIND_WRITE);
                  nxt_memAddr  = reqAddr;
                  nxt_memWdata = reqWdata;
                  if (reqKind == `SAG_KIND_WRITE) begin
                     nxt_rspValid  = 1'b1;
                     nxt_rspData   = {DW{1'b0}};
                     nxt_rspDenied = 1'b0;
                  end else begin
                     nxt_state = S_RWT;
                  end
               end else begin
                  // no memory cycle at all, so nothing can leak or change
                  nxt_rspValid  = 1'b1;
                  nxt_rspData   = `SAG_BLOCK_VAL;
                  nxt_rspDenied = 1'b1;
               end
            end
         end
         S_RWT: begin
            nxt_state = S_RCAP;
         end
         S_RCAP: begin
            nxt_rspValid  = 1'b1;
            nxt_rspData   = memRdata;
            nxt_rspDenied = 1'b0;
            nxt_state     = S_IDLE;
         end
         S_PWT: begin
            nxt_state = S_PCAP;
         end
         S_PCAP: begin
            nxt_rspData = {DW{1'b0}};
            nxt_state   = S_IDLE;
            if (src_ff == `SAG_SRC_DBG) begin
               nxt_dbgOpen   = pwMatch;
               nxt_rspValid  = 1'b1;
               nxt_rspDenied = !pwMatch;
            end else if (pwLast && !pwOk) begin
               nxt_blOpen   = 1'b0;
               nxt_eraseCnt = {AW{1'b0}};
               nxt_state    = S_ERASE;
            end else begin
               nxt_blOpen    = pwLast ? 1'b1 : blOpen_ff;
               nxt_rspValid  = 1'b1;
               nxt_rspDenied = 1'b0;
            end
         end
         S_ERASE: begin
            // one word per cycle; the answer is issued together with the last erase write
            nxt_memReq   = 1'b1;
            nxt_memWe    = 1'b1;
            nxt_memAddr  = `SAG_CODE_BASE + eraseCnt_ff;
            nxt_memWdata = `SAG_ERASE_VAL;
            nxt_eraseCnt = eraseCnt_ff + {{(AW-1){1'b0}}, 1'b1};
            if (eraseCnt_ff == CODE_WORDS - {{(AW-1){1'b0}}, 1'b1}) begin
               nxt_eraseCnt  = {AW{1'b0}};
               nxt_rspValid  = 1'b1;
               nxt_rspData   = `SAG_BLOCK_VAL;
               nxt_rspDenied = 1'b1;
               nxt_state     = S_IDLE;
            end
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
   end

   // ***************************************************
   // registers
   // ***************************************************
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff       <= S_BRD;
         bootIdx_ff     <= 2'h0;
         src_ff         <= 2'h0;
         wdata_ff       <= {DW{1'b0}};
         zoneLo_ff      <= {AW{1'b0}};
         zoneHi_ff      <= {AW{1'b0}};
         zctl_ff        <= {DW{1'b0}};
         eraseCnt_ff    <= {AW{1'b0}};
         busy_ff        <= 1'b1;
         rspValid_ff    <= 1'b0;
         rspData_ff     <= {DW{1'b0}};
         rspDenied_ff   <= 1'b0;
         memReq_ff      <= 1'b0;
         memWe_ff       <= 1'b0;
         memAddr_ff     <= {AW{1'b0}};
         memWdata_ff    <= {DW{1'b0}};
         // safest until the fuse word is read: debug treated as off
         dbgMode_ff     <= `SAG_DBG_OFF;
         dbgOpen_ff     <= 1'b0;
         blOpen_ff      <= 1'b0;
         zoneMapped_ff  <= 1'b0;
         eraseActive_ff <= 1'b0;
      end else begin
         state_ff       <= nxt_state;
         bootIdx_ff     <= nxt_bootIdx;
         src_ff         <= nxt_src;
         wdata_ff       <= nxt_wdata;
         zoneLo_ff      <= nxt_zoneLo;
         zoneHi_ff      <= nxt_zoneHi;
         zctl_ff        <= nxt_zctl;
         eraseCnt_ff    <= nxt_eraseCnt;
         busy_ff        <= (nxt_state != S_IDLE);
         rspValid_ff    <= nxt_rspValid;
         rspData_ff     <= nxt_rspData;
         rspDenied_ff   <= nxt_rspDenied;
         memReq_ff      <= nxt_memReq;
         memWe_ff       <= nxt_memWe;
         memAddr_ff     <= nxt_memAddr;
         memWdata_ff    <= nxt_memWdata;
         dbgMode_ff     <= nxt_dbgMode;
         dbgOpen_ff     <= nxt_dbgOpen;
         blOpen_ff      <= nxt_blOpen;
         zoneMapped_ff  <= nxt_zoneMapped;
         eraseActive_ff <= (nxt_state == S_ERASE);
      end
   end
endmodule // sag_guard

// [bench/sag_guard_chk.sv]
`include "sag_regs.vh"

// ***************************************************
// port checker for the access guard
// ***************************************************
module sag_guard_chk (
   input logic        clk_sys, rstn, reqValid, cpuCall, busy_ff, rspValid_ff, rspDenied_ff,
   input logic        memReq_ff, memWe_ff, dbgOpen_ff, blOpen_ff, zoneMapped_ff, eraseActive_ff,
   input logic [1:0]  reqSrc, reqKind, dbgMode_ff,
   input logic [15:0] reqAddr, reqWdata, cpuPc, rspData_ff, memAddr_ff, memWdata_ff, memRdata
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   wire take   = reqValid && !busy_ff;
   wire notPwd = reqKind != `SAG_KIND_PWD;
   wire reqCfg = reqAddr == `SAG_ZLO_ADDR || reqAddr == `SAG_ZHI_ADDR || reqAddr == `SAG_ZCTL_ADDR;
   wire memCfg = memAddr_ff == `SAG_ZLO_ADDR || memAddr_ff == `SAG_ZHI_ADDR
              || memAddr_ff == `SAG_ZCTL_ADDR;
   // the boot map step itself stores the mapped mark
   wire mapMark = memAddr_ff == `SAG_ZCTL_ADDR && memWdata_ff == `SAG_ZCTL_MAPPED;

   sequence sRefuse;
      ##1 rspValid_ff && rspDenied_ff && rspData_ff == `SAG_BLOCK_VAL && !memReq_ff;
   endsequence
   sequence sVecRead;
      ##1 memReq_ff && !memWe_ff && memAddr_ff >= `SAG_VEC_BASE
          && memAddr_ff < `SAG_VEC_BASE + `SAG_VEC_WORDS;
   endsequence
   sequence sEraseTwo;
      eraseActive_ff && memReq_ff ##1 eraseActive_ff && memReq_ff;
   endsequence

   a_dbg_off_deny: assert property (take && reqSrc == `SAG_SRC_DBG && notPwd
      && dbgMode_ff == `SAG_DBG_OFF |-> sRefuse) else $error("debug access while off");
   a_dbg_lock_deny: assert property (take && reqSrc == `SAG_SRC_DBG && notPwd
      && dbgMode_ff == `SAG_DBG_PWD && !dbgOpen_ff |-> sRefuse) else $error("locked debug");
   a_bl_lock_deny: assert property (take && reqSrc == `SAG_SRC_BL && notPwd
      && !blOpen_ff |-> sRefuse) else $error("boot loader not locked");
   a_cfg_write_deny: assert property (take && reqKind == `SAG_KIND_WRITE
      && zoneMapped_ff && reqCfg |-> sRefuse) else $error("zone range write taken");
   a_cfg_frozen: assert property (memReq_ff && memWe_ff && zoneMapped_ff
      && !eraseActive_ff && !mapMark |-> !memCfg) else $error("zone range word written");
   a_vec_compare: assert property (take && reqSrc == `SAG_SRC_BL
      && reqKind == `SAG_KIND_PWD |-> sVecRead) else $error("password not against vectors");
   a_erase_fill: assert property (eraseActive_ff && memReq_ff |-> memWe_ff
      && memWdata_ff == `SAG_ERASE_VAL && memAddr_ff >= `SAG_CODE_BASE) else $error("bad erase");
   a_erase_step: assert property (sEraseTwo |-> memAddr_ff == $past(memAddr_ff) + 16'h0001)
      else $error("erase address skipped");
   a_erase_end: assert property ($fell(eraseActive_ff)
      |-> ##[0:3] rspValid_ff && rspDenied_ff && !blOpen_ff) else $error("erase end answer");
endmodule // sag_guard_chk

bind sag_guard sag_guard_chk sag_guard_chk_inst (
   .clk_sys(clk_sys), .rstn(rstn), .reqValid(reqValid), .cpuCall(cpuCall), .busy_ff(busy_ff),
   .rspValid_ff(rspValid_ff), .rspDenied_ff(rspDenied_ff), .memReq_ff(memReq_ff),
   .memWe_ff(memWe_ff), .dbgOpen_ff(dbgOpen_ff), .blOpen_ff(blOpen_ff),
   .zoneMapped_ff(zoneMapped_ff), .eraseActive_ff(eraseActive_ff), .reqSrc(reqSrc),
   .reqKind(reqKind), .dbgMode_ff(dbgMode_ff), .reqAddr(reqAddr), .reqWdata(reqWdata),
   .cpuPc(cpuPc), .rspData_ff(rspData_ff), .memAddr_ff(memAddr_ff), .memWdata_ff(memWdata_ff),
   .memRdata(memRdata));

// [bench/sag_mem_model.sv]
// ***************************************************
// code memory, one cycle read latency
// ***************************************************
module sag_mem_model (
   input  wire logic        clk_sys,
   input  wire logic        memReq_ff,
   input  wire logic        memWe_ff,
   input  wire logic [15:0] memAddr_ff,
   input  wire logic [15:0] memWdata_ff,
   output logic      [15:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:65535];
   initial memRdata = 16'h0000;
   always @(posedge clk_sys) begin
      if (memReq_ff && memWe_ff) mem[memAddr_ff] <= memWdata_ff;
      // no read: data turns over so stale words never look valid
      memRdata <= (memReq_ff && !memWe_ff) ? mem[memAddr_ff] : ~memRdata;
   end
endmodule // sag_mem_model

// [bench/test_secure_access_guard.sv]
`include "sag_regs.vh"

module test_secure_access_guard;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, rstn = 1'b0, reqValid = 1'b0, cpuCall = 1'b0;
   logic [1:0] reqSrc = 2'h0, reqKind = 2'h0;
   logic [15:0] reqAddr = 16'h0000, reqWdata = 16'h0000, cpuPc = 16'h0000;
   wire busy_ff, rspValid_ff, rspDenied_ff, memReq_ff, memWe_ff;
   wire dbgOpen_ff, blOpen_ff, zoneMapped_ff, eraseActive_ff;
   wire [1:0] dbgMode_ff;
   wire [15:0] rspData_ff, memAddr_ff, memWdata_ff, memRdata;
   int fail_count = 0, compares = 0, i;
   always #5 clk_sys = ~clk_sys;

   // short code area keeps the erase walk brief
   sag_guard #(.CODE_WORDS(16'h0010)) sag_guard_inst (.clk_sys(clk_sys), .rstn(rstn),
      .reqValid(reqValid), .reqSrc(reqSrc), .reqKind(reqKind), .reqAddr(reqAddr),
      .reqWdata(reqWdata), .cpuPc(cpuPc), .cpuCall(cpuCall), .busy_ff(busy_ff),
      .rspValid_ff(rspValid_ff), .rspData_ff(rspData_ff), .rspDenied_ff(rspDenied_ff),
      .memReq_ff(memReq_ff), .memWe_ff(memWe_ff), .memAddr_ff(memAddr_ff),
      .memWdata_ff(memWdata_ff), .memRdata(memRdata), .dbgMode_ff(dbgMode_ff),
      .dbgOpen_ff(dbgOpen_ff), .blOpen_ff(blOpen_ff), .zoneMapped_ff(zoneMapped_ff),
      .eraseActive_ff(eraseActive_ff));
   sag_mem_model sag_mem_model_inst (.clk_sys(clk_sys), .memReq_ff(memReq_ff),
      .memWe_ff(memWe_ff), .memAddr_ff(memAddr_ff), .memWdata_ff(memWdata_ff),
      .memRdata(memRdata));

   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic close_out();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic boot();
      int n;
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      for (n = 0; n < 100 && busy_ff !== 1'b0; n++) @(posedge clk_sys) #1;
      if (busy_ff !== 1'b0) begin
         fail_count++;
         $display("[FAIL] %0t boot hangs", $time);
         close_out();
      end
   endtask

   task automatic req(input logic [1:0] s, input logic [1:0] k, input logic [15:0] a,
                      input logic [15:0] w, input logic [15:0] pc, input logic c);
      int n;
      @(posedge clk_sys);
      reqSrc <= s; reqKind <= k; reqAddr <= a; reqWdata <= w; cpuPc <= pc; cpuCall <= c;
      reqValid <= 1'b1;
      @(posedge clk_sys);
      reqValid <= 1'b0;
      #1;
      for (n = 0; n < 100 && rspValid_ff !== 1'b1; n++) @(posedge clk_sys) #1;
      if (rspValid_ff !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t no answer", $time);
         close_out();
      end
   endtask

   task automatic rd(input logic [1:0] s, input logic [15:0] a, input logic [15:0] pc,
                     input logic [15:0] exp, input logic den);
      req(s, `SAG_KIND_READ, a, 16'h0000, pc, 1'b0);
      chk(rspData_ff, exp, "read data");
      chk({15'h0000, rspDenied_ff}, {15'h0000, den}, "read refusal");
   endtask

   // one word off when bad names a word index
   task automatic blPwd(input int bad);
      for (int j = 0; j < 16; j++)
         req(`SAG_SRC_BL, `SAG_KIND_PWD, 16'h0000, (j == bad) ? 16'h3C00 : 16'hC000 | j,
             16'h0000, 1'b0);
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_map();
      boot();
      @(posedge clk_sys) #1;
      chk(sag_mem_model_inst.mem[`SAG_ZCTL_ADDR], `SAG_ZCTL_MAPPED, "map mark");
      boot();
      chk({15'h0000, zoneMapped_ff}, 16'h0001, "zone mapped");
      $display("test map done");
   endtask

   task automatic t_zone();
      rd(`SAG_SRC_DMA, 16'h5000, 16'h4000, `SAG_BLOCK_VAL, 1'b1);
      rd(`SAG_SRC_CPU, 16'h5000, 16'h4000, `SAG_BLOCK_VAL, 1'b1);
      rd(`SAG_SRC_CPU, 16'h5000, 16'h50FF, 16'hBEEF, 1'b0);
      req(`SAG_SRC_CPU, `SAG_KIND_FETCH, 16'h5001, 16'h0000, 16'h4000, 1'b1);
      chk(rspData_ff, 16'h4242, "called fetch");
      req(`SAG_SRC_CPU, `SAG_KIND_FETCH, 16'h5001, 16'h0000, 16'h4000, 1'b0);
      chk({15'h0000, rspDenied_ff}, 16'h0001, "plain fetch");
      req(`SAG_SRC_CPU, `SAG_KIND_WRITE, 16'h5000, 16'h0BAD, 16'h4000, 1'b0);
      rd(`SAG_SRC_CPU, 16'h5000, 16'h5000, 16'hBEEF, 1'b0);
      req(`SAG_SRC_CPU, `SAG_KIND_WRITE, `SAG_ZLO_ADDR, 16'h0000, 16'h5000, 1'b0);
      chk(sag_mem_model_inst.mem[`SAG_ZLO_ADDR], 16'h5000, "range kept");
      $display("test zone done");
   endtask

   task automatic t_dbg();
      chk({14'h0000, dbgMode_ff}, {14'h0000, `SAG_DBG_PWD}, "debug mode");
      rd(`SAG_SRC_DBG, 16'h4000, 16'h0000, `SAG_BLOCK_VAL, 1'b1);
      req(`SAG_SRC_DBG, `SAG_KIND_PWD, 16'h0000, 16'h9999, 16'h0000, 1'b0);
      chk({15'h0000, dbgOpen_ff}, 16'h0000, "wrong debug key");
      req(`SAG_SRC_DBG, `SAG_KIND_PWD, 16'h0000, 16'h1234, 16'h0000, 1'b0);
      chk({15'h0000, dbgOpen_ff}, 16'h0001, "debug key");
      rd(`SAG_SRC_DBG, 16'h4000, 16'h0000, 16'h0100, 1'b0);
      rd(`SAG_SRC_DBG, 16'h5000, 16'h0000, `SAG_BLOCK_VAL, 1'b1);
      $display("test debug done");
   endtask

   task automatic t_bl();
      rd(`SAG_SRC_BL, 16'h4000, 16'h0000, `SAG_BLOCK_VAL, 1'b1);
      blPwd(-1);
      chk({15'h0000, blOpen_ff}, 16'h0001, "vector key");
      rd(`SAG_SRC_BL, 16'h4001, 16'h0000, 16'h0101, 1'b0);
      rd(`SAG_SRC_BL, 16'h5000, 16'h0000, `SAG_BLOCK_VAL, 1'b1);
      blPwd(15);
      chk({15'h0000, rspDenied_ff}, 16'h0001, "wrong key answer");
      chk({15'h0000, blOpen_ff}, 16'h0000, "relocked");
      // last erase word is stored one edge after the answer
      @(posedge clk_sys) #1;
      for (i = 0; i < 16; i++)
         chk(sag_mem_model_inst.mem[16'h4000 + i], `SAG_ERASE_VAL, "erased");
      chk(sag_mem_model_inst.mem[16'h4010], 16'h7777, "past code area");
      $display("test boot loader done");
   endtask

   task automatic t_off();
      sag_mem_model_inst.mem[`SAG_FUSE_ADDR] = `SAG_FUSE_OFF;
      boot();
      chk({14'h0000, dbgMode_ff}, {14'h0000, `SAG_DBG_OFF}, "debug off");
      req(`SAG_SRC_DBG, `SAG_KIND_PWD, 16'h0000, 16'h1234, 16'h0000, 1'b0);
      chk({15'h0000, dbgOpen_ff}, 16'h0000, "key ignored");
      rd(`SAG_SRC_DBG, 16'h4010, 16'h0000, `SAG_BLOCK_VAL, 1'b1);
      blPwd(-1);
      rd(`SAG_SRC_BL, 16'h4010, 16'h0000, 16'h7777, 1'b0);
      $display("test fuse off done");
   endtask

   initial begin
      sag_mem_model_inst.mem[`SAG_FUSE_ADDR] = `SAG_FUSE_PWD;
      sag_mem_model_inst.mem[`SAG_DBG_PWD_ADDR] = 16'h1234;
      sag_mem_model_inst.mem[`SAG_ZLO_ADDR] = 16'h5000;
      sag_mem_model_inst.mem[`SAG_ZHI_ADDR] = 16'h50FF;
      sag_mem_model_inst.mem[`SAG_ZCTL_ADDR] = `SAG_ZCTL_ARM;
      sag_mem_model_inst.mem[16'h5000] = 16'hBEEF;
      sag_mem_model_inst.mem[16'h5001] = 16'h4242;
      sag_mem_model_inst.mem[16'h4010] = 16'h7777;
      for (i = 0; i < 16; i++) begin
         sag_mem_model_inst.mem[`SAG_VEC_BASE + i] = 16'hC000 | i;
         sag_mem_model_inst.mem[16'h4000 + i] = 16'h0100 + i;
      end
      t_map();
      t_zone();
      t_dbg();
      t_bl();
      t_off();
      close_out();
   end
endmodule // test_secure_access_guard
